// ==== rtl/monitor_channel.sv ====
// One monitor channel: source, axis and instance selections and
// the registered value of the variable they pick.
// Assumes writes come from the parameter port on the same clock.
`timescale 1ns/1ps
`include "safety_state_defs.svh"
module monitor_channel #(
	parameter bit DUAL_AXIS = 1'b1
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Selection write
	input  wire logic        wr_i,
	input  wire logic [2:0]  sel_i,
	input  wire logic [7:0]  wdata_i,
	output logic             wr_err_o,
	// Monitored variables, axis 2 or brake 2 in the upper byte
	input  wire logic [15:0] torque_off_i,
	input  wire logic [15:0] ctl_stop_i,
	input  wire logic [15:0] brake_ctl_i,
	input  wire logic [15:0] brake_i,
	// Selections and value
	output logic [7:0]       source_o,
	output logic [7:0]       axis_o,
	output logic [7:0]       instance_o,
	output logic [31:0]      value_o
);
	logic [7:0] src_reg;
	logic [7:0] axis_reg;
	logic [7:0] inst_reg;
	logic [31:0] value_reg;
	wire wr_src = wr_i && (sel_i == `PSEL_SRC);
	wire wr_axis = wr_i && (sel_i == `PSEL_AXIS);
	wire wr_inst = wr_i && (sel_i == `PSEL_INST);
	wire src_ok = (wdata_i <= `SRC_MAX);
	wire axis_ok = (wdata_i == `AXIS_MIN) || (DUAL_AXIS && (wdata_i == `AXIS_MAX));
	wire inst_ok = (wdata_i >= `INST_MIN) && (wdata_i <= `INST_MAX);
	assign wr_err_o = (wr_src && !src_ok) || (wr_axis && !axis_ok) || (wr_inst && !inst_ok);

	// ----------------------------------------------------------------
	// Variable selection
	// ----------------------------------------------------------------
	// Axis is ignored for the brake source; instance picks the brake
	wire axis_hi = (axis_reg == `AXIS_MAX);
	wire [7:0] torque_sel = axis_hi ? torque_off_i[15:8] : torque_off_i[7:0];
	wire [7:0] stop_sel = axis_hi ? ctl_stop_i[15:8] : ctl_stop_i[7:0];
	wire [7:0] bctl_sel = axis_hi ? brake_ctl_i[15:8] : brake_ctl_i[7:0];
	wire [7:0] brake_sel = (inst_reg == 8'h01) ? brake_i[7:0] :
		(inst_reg == 8'h02) ? brake_i[15:8] : 8'h00;
	// Reserved sources 0 and 5 to 20 read as zero
	wire [7:0] pick = (src_reg == `SRC_TORQUE_OFF) ? torque_sel :
		(src_reg == `SRC_CTL_STOP) ? stop_sel :
		(src_reg == `SRC_BRAKE_CTL) ? bctl_sel :
		(src_reg == `SRC_BRAKE) ? brake_sel : 8'h00;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_reg <= `SRC_RST;
			axis_reg <= `AXIS_RST;
			inst_reg <= `INST_RST;
			value_reg <= 32'h0;
		end else begin
			if (wr_src && src_ok) src_reg <= wdata_i;
			if (wr_axis && axis_ok) axis_reg <= wdata_i;
			if (wr_inst && inst_ok) inst_reg <= wdata_i;
			value_reg <= {24'h0, pick};
		end
	end
	assign source_o = src_reg;
	assign axis_o = axis_reg;
	assign instance_o = inst_reg;
	assign value_o = value_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_src_range: assert property (wr_src && wdata_i > `SRC_MAX |=> $stable(source_o))
		else $error("source accepted out of range");
	a_axis_range: assert property (wr_axis && !axis_ok |=> $stable(axis_o) && axis_o != 8'h00)
		else $error("axis accepted out of range");
	a_inst_range: assert property (wr_inst && wdata_i == 8'h05 |=> $stable(instance_o))
		else $error("instance accepted out of range");
	a_brake_value: assert property (source_o == 8'h04 && instance_o == 8'h02 |=> value_o == {24'h0, $past(brake_i[15:8])})
		else $error("brake 2 not returned");
	a_stop_value: assert property (source_o == 8'h02 && axis_o == 8'h01 |=> value_o == {24'h0, $past(ctl_stop_i[7:0])})
		else $error("stop state not returned");
endmodule

// ==== rtl/safety_state_defs.svh ====
// Constants of the safety state and monitor block: state codes,
// selection ranges and defaults, access codes and command limits.
// Assumes inclusion by bare name from the rtl folder.
`ifndef SAFETY_STATE_DEFS_SVH
`define SAFETY_STATE_DEFS_SVH

// ----------------------------------------------------------------
// Module state codes
// ----------------------------------------------------------------
`define CODE_STARTUP     8'h01
`define CODE_ADDR_BAD    8'h02
`define CODE_CFG_REQ     8'h03
`define CODE_CFG_BAD     8'h04
`define CODE_PARAM_VAL   8'h05
`define CODE_NORMAL      8'h06
`define CODE_BRAKE_TEST  8'h07
`define CODE_IO_FAIL     8'h08
`define CODE_INT_FAIL    8'h09

// ----------------------------------------------------------------
// Monitor selections
// ----------------------------------------------------------------
`define SRC_RST          8'h01
`define SRC_TORQUE_OFF   8'h01
`define SRC_CTL_STOP     8'h02
`define SRC_BRAKE_CTL    8'h03
`define SRC_BRAKE        8'h04
`define SRC_MAX          8'h14
`define AXIS_RST         8'h01
`define AXIS_MIN         8'h01
`define AXIS_MAX         8'h02
`define INST_RST         8'h01
`define INST_MIN         8'h01
`define INST_MAX         8'h04

// ----------------------------------------------------------------
// Parameter access selector and object dictionary entry
// ----------------------------------------------------------------
`define PSEL_STATE       3'h0
`define PSEL_SRC         3'h1
`define PSEL_AXIS        3'h2
`define PSEL_INST        3'h3
`define PSEL_DATA        3'h4
`define OD_STATE_INDEX   16'h37c1
`define OD_STATE_SUB     8'h00

// ----------------------------------------------------------------
// Invalidation command argument limits
// ----------------------------------------------------------------
`define NAME_LEN_MIN     5'h01
`define NAME_LEN_MAX     5'h08
`define PASS_LEN_MIN     5'h08
`define PASS_LEN_MAX     5'h19

`endif

// ==== rtl/safety_state_monitor.sv ====
// Safety module status and diagnostic front end: module state,
// two monitor channels, and the parameter invalidation command.
// Assumes a shell parser and fieldbus stack on the same clock deliver
// requests as one-cycle strobes; the brake test request is a pin.
// Operation
// - Invalidation accepted only in normal operation
// - Accepted invalidation drops params, goes code 3
// - Two independent monitor channels, read concurrently
// - Axis accepts 1, or 1-2 dual; default 1
// - Instance accepts 1 to 4, default 1
// - Sources 1-3 pick torque-off, stop, brake-control
// - Source 4 picks brake by instance, ignores axis
// - Source 0 to 20, default 1; 5+ reserved
// - Value returns current state of selected variable
// - State readable by shell and object 0x37C1/0
// - Code 1 while fieldbus link starts up
// - Code 2 while safety address not validated
// - Codes 3, 4, 5 for configuration conditions
// - Code 6 in normal operation
// - Brake test reports code 7 device-wide
// - Code 8 holds torque-off and brakes active
// - Code 9 latched until power cycle
`timescale 1ns/1ps
`include "safety_state_defs.svh"
module safety_state_monitor
	import safety_state_pkg::*;
#(
	parameter bit DUAL_AXIS = 1'b1
) (
	// Clock and reset
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_I,
	// Parameter access from the text shell
	input  wire logic        PAR_REQ_I,
	input  wire logic        PAR_WR_I,
	input  wire logic        PAR_CH_I,
	input  wire logic [2:0]  PAR_SEL_I,
	input  wire logic [7:0]  PAR_WDATA_I,
	output logic             PAR_ACK_O,
	output logic             PAR_ERR_O,
	output logic [31:0]      PAR_RDATA_O,
	// Object dictionary read from the fieldbus
	input  wire logic        OD_REQ_I,
	input  wire logic [15:0] OD_INDEX_I,
	input  wire logic [7:0]  OD_SUB_I,
	output logic             OD_ACK_O,
	output logic             OD_ERR_O,
	output logic [7:0]       OD_DATA_O,
	// Invalidation command, arguments already parsed
	input  wire logic        INV_REQ_I,
	input  wire logic [4:0]  INV_NAME_LEN_I,
	input  wire logic [4:0]  INV_PASS_LEN_I,
	input  wire logic        INV_TIME_OK_I,
	output logic             INV_ACK_O,
	output logic             INV_ERR_O,
	// Status events from the safety core
	input  wire logic        FIELDBUS_UP_I,
	input  wire logic        ADDR_VALID_I,
	input  wire logic        CFG_LOAD_I,
	input  wire logic        CFG_BAD_I,
	input  wire logic        PARAM_VALIDATE_I,
	input  wire logic        IO_FAULT_I,
	input  wire logic        IO_ACK_I,
	input  wire logic        FATAL_I,
	// Brake test request from the drive processor
	input  wire logic        BRAKE_TEST_I,
	// Safety function states, axis 2 or brake 2 in the upper byte
	input  wire logic [15:0] TORQUE_OFF_STATE_I,
	input  wire logic [15:0] CTL_STOP_STATE_I,
	input  wire logic [15:0] BRAKE_CTL_STATE_I,
	input  wire logic [15:0] BRAKE_STATE_I,
	// Status outputs
	output logic [7:0]       MODULE_STATE_O,
	output logic             PARAMS_VALID_O,
	output logic             TORQUE_OFF_FORCE_O,
	output logic [1:0]       BRAKE_FORCE_O,
	output logic [31:0]      MON1_VALUE_O,
	output logic [31:0]      MON2_VALUE_O
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	mstate_t     state_reg;
	mstate_t     state_next;
	mstate_t     ready_state;
	logic        brk_meta_reg;
	logic        brk_sync_reg;
	logic        cfg_loaded_reg;
	logic        params_valid_reg;
	logic [7:0]  code_reg;
	logic        force_reg;
	logic        par_ack_reg;
	logic        par_err_reg;
	logic [31:0] par_rdata_reg;
	logic        od_ack_reg;
	logic        od_err_reg;
	logic [7:0]  od_data_reg;
	logic        inv_ack_reg;
	logic        inv_err_reg;
	logic [1:0]  mon_wr;
	logic [1:0]  mon_err;
	logic [7:0]  mon_src [2];
	logic [7:0]  mon_axis [2];
	logic [7:0]  mon_inst [2];
	logic [31:0] mon_value [2];

	function automatic logic [7:0] code_of(input mstate_t s);
		case (s)
			MS_STARTUP:    code_of = `CODE_STARTUP;
			MS_ADDR_BAD:   code_of = `CODE_ADDR_BAD;
			MS_CFG_REQ:    code_of = `CODE_CFG_REQ;
			MS_CFG_BAD:    code_of = `CODE_CFG_BAD;
			MS_PARAM_VAL:  code_of = `CODE_PARAM_VAL;
			MS_NORMAL:     code_of = `CODE_NORMAL;
			MS_BRAKE_TEST: code_of = `CODE_BRAKE_TEST;
			MS_IO_FAIL:    code_of = `CODE_IO_FAIL;
			default:       code_of = `CODE_INT_FAIL;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Brake test request synchroniser
	// ----------------------------------------------------------------
	// The request comes from another processor, so it is resampled
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			brk_meta_reg <= 1'b0;
			brk_sync_reg <= 1'b0;
		end else begin
			brk_meta_reg <= BRAKE_TEST_I;
			brk_sync_reg <= brk_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// Invalidation command
	// ----------------------------------------------------------------
	// Argument lengths are checked here although the host owns them,
	// so a malformed command never reaches the parameter store
	wire name_ok = (INV_NAME_LEN_I >= `NAME_LEN_MIN) && (INV_NAME_LEN_I <= `NAME_LEN_MAX);
	wire pass_ok = (INV_PASS_LEN_I >= `PASS_LEN_MIN) && (INV_PASS_LEN_I <= `PASS_LEN_MAX);
	wire args_ok = name_ok && pass_ok && INV_TIME_OK_I;
	wire inv_accept = INV_REQ_I && (state_reg == MS_NORMAL) && args_ok;
	wire inv_reject = INV_REQ_I && !inv_accept;

	// ----------------------------------------------------------------
	// Parameter validity flags
	// ----------------------------------------------------------------
	// A load or validation in the same cycle as an invalidation wins
	wire cfg_loaded_next = CFG_LOAD_I ? 1'b1 : (inv_accept ? 1'b0 : cfg_loaded_reg);
	wire params_valid_next = PARAM_VALIDATE_I ? 1'b1 :
		((inv_accept || CFG_LOAD_I) ? 1'b0 : params_valid_reg);

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			cfg_loaded_reg <= 1'b0;
			params_valid_reg <= 1'b0;
		end else begin
			cfg_loaded_reg <= cfg_loaded_next;
			params_valid_reg <= params_valid_next;
		end
	end

	// ----------------------------------------------------------------
	// Module state machine
	// ----------------------------------------------------------------
	// Start-up conditions in order of precedence
	always_comb begin
		if (!FIELDBUS_UP_I) begin
			ready_state = MS_STARTUP;
		end else if (!ADDR_VALID_I) begin
			ready_state = MS_ADDR_BAD;
		end else if (CFG_BAD_I) begin
			ready_state = MS_CFG_BAD;
		end else if (!cfg_loaded_reg) begin
			ready_state = MS_CFG_REQ;
		end else if (!params_valid_reg) begin
			ready_state = MS_PARAM_VAL;
		end else begin
			ready_state = MS_NORMAL;
		end
	end

	always_comb begin
		state_next = state_reg;
		if (FATAL_I || state_reg == MS_INT_FAIL) begin
			state_next = MS_INT_FAIL;
		end else if (IO_FAULT_I) begin
			state_next = MS_IO_FAIL;
		end else begin
			case (state_reg)
				MS_IO_FAIL: begin
					if (IO_ACK_I) state_next = ready_state;
				end
				MS_BRAKE_TEST: begin
					if (!brk_sync_reg) state_next = MS_NORMAL;
				end
				MS_NORMAL: begin
					if (inv_accept) begin
						state_next = MS_CFG_REQ;
					end else if (ready_state != MS_NORMAL) begin
						state_next = ready_state;
					end else if (brk_sync_reg) begin
						state_next = MS_BRAKE_TEST;
					end
				end
				default: begin
					state_next = ready_state;
				end
			endcase
		end
	end

	// Fault states force torque-off and both brakes
	wire force_next = (state_next == MS_IO_FAIL) || (state_next == MS_INT_FAIL);

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			state_reg <= MS_STARTUP;
			code_reg <= `CODE_STARTUP;
			force_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			code_reg <= code_of(state_next);
			force_reg <= force_next;
		end
	end

	// ----------------------------------------------------------------
	// Monitor channels
	// ----------------------------------------------------------------
	wire sel_cfg = (PAR_SEL_I == `PSEL_SRC) || (PAR_SEL_I == `PSEL_AXIS) ||
		(PAR_SEL_I == `PSEL_INST);
	wire sel_known = sel_cfg || (PAR_SEL_I == `PSEL_STATE) || (PAR_SEL_I == `PSEL_DATA);
	wire par_wr_cfg = PAR_REQ_I && PAR_WR_I && sel_cfg;
	assign mon_wr = {par_wr_cfg && PAR_CH_I, par_wr_cfg && !PAR_CH_I};

	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_mon
			monitor_channel #(
				.DUAL_AXIS (DUAL_AXIS)
			) u_chan (
				.clk_i        (CLK_SYS_I),
				.rst_i        (RST_I),
				.wr_i         (mon_wr[ch]),
				.sel_i        (PAR_SEL_I),
				.wdata_i      (PAR_WDATA_I),
				.wr_err_o     (mon_err[ch]),
				.torque_off_i (TORQUE_OFF_STATE_I),
				.ctl_stop_i   (CTL_STOP_STATE_I),
				.brake_ctl_i  (BRAKE_CTL_STATE_I),
				.brake_i      (BRAKE_STATE_I),
				.source_o     (mon_src[ch]),
				.axis_o       (mon_axis[ch]),
				.instance_o   (mon_inst[ch]),
				.value_o      (mon_value[ch])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Parameter access port
	// ----------------------------------------------------------------
	// State and value are read-only; unknown selectors are refused
	wire ch_idx = PAR_CH_I;
	wire chan_err = mon_err[ch_idx];
	wire par_err = PAR_REQ_I && (!sel_known || (PAR_WR_I && !sel_cfg) || chan_err);
	wire [31:0] par_rd =
		(PAR_SEL_I == `PSEL_STATE) ? {24'h0, code_reg} :
		(PAR_SEL_I == `PSEL_SRC)   ? {24'h0, mon_src[ch_idx]} :
		(PAR_SEL_I == `PSEL_AXIS)  ? {24'h0, mon_axis[ch_idx]} :
		(PAR_SEL_I == `PSEL_INST)  ? {24'h0, mon_inst[ch_idx]} :
		(PAR_SEL_I == `PSEL_DATA)  ? mon_value[ch_idx] : 32'h0;
	wire par_rd_ok = PAR_REQ_I && !PAR_WR_I && sel_known;

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			par_ack_reg <= 1'b0;
			par_err_reg <= 1'b0;
			par_rdata_reg <= 32'h0;
		end else begin
			par_ack_reg <= PAR_REQ_I;
			par_err_reg <= par_err;
			par_rdata_reg <= par_rd_ok ? par_rd : 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Object dictionary and command answers
	// ----------------------------------------------------------------
	wire od_hit = (OD_INDEX_I == `OD_STATE_INDEX) && (OD_SUB_I == `OD_STATE_SUB);

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			od_ack_reg <= 1'b0;
			od_err_reg <= 1'b0;
			od_data_reg <= 8'h00;
			inv_ack_reg <= 1'b0;
			inv_err_reg <= 1'b0;
		end else begin
			od_ack_reg <= OD_REQ_I;
			od_err_reg <= OD_REQ_I && !od_hit;
			od_data_reg <= (OD_REQ_I && od_hit) ? code_reg : 8'h00;
			inv_ack_reg <= INV_REQ_I;
			inv_err_reg <= inv_reject;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign PAR_ACK_O = par_ack_reg;
	assign PAR_ERR_O = par_err_reg;
	assign PAR_RDATA_O = par_rdata_reg;
	assign OD_ACK_O = od_ack_reg;
	assign OD_ERR_O = od_err_reg;
	assign OD_DATA_O = od_data_reg;
	assign INV_ACK_O = inv_ack_reg;
	assign INV_ERR_O = inv_err_reg;
	assign MODULE_STATE_O = code_reg;
	assign PARAMS_VALID_O = params_valid_reg;
	assign TORQUE_OFF_FORCE_O = force_reg;
	assign BRAKE_FORCE_O = {force_reg, force_reg};
	assign MON1_VALUE_O = mon_value[0];
	assign MON2_VALUE_O = mon_value[1];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);

	wire quiet = !FATAL_I && !IO_FAULT_I;
	sequence s_inv_good;
		INV_REQ_I && args_ok && state_reg == MS_NORMAL && quiet && !PARAM_VALIDATE_I;
	endsequence
	sequence s_cfg_req_held;
		MODULE_STATE_O == 8'h03 && !PARAMS_VALID_O && INV_ACK_O && !INV_ERR_O;
	endsequence

	a_inv_only_normal: assert property (INV_REQ_I && state_reg != MS_NORMAL |=> INV_ACK_O && INV_ERR_O)
		else $error("invalidation accepted outside normal operation");
	a_inv_to_cfg: assert property (s_inv_good |=> s_cfg_req_held)
		else $error("accepted invalidation did not reach code 3");
	a_inv_bad_args: assert property (INV_REQ_I && INV_PASS_LEN_I < 5'h08 && state_reg == MS_NORMAL && quiet && !brk_sync_reg && ready_state == MS_NORMAL |=> INV_ERR_O && MODULE_STATE_O == 8'h06)
		else $error("short password not refused");
	a_od_state: assert property (OD_REQ_I && OD_INDEX_I == 16'h37c1 && OD_SUB_I == 8'h00 |=> OD_ACK_O && !OD_ERR_O && OD_DATA_O == $past(MODULE_STATE_O))
		else $error("object read did not return state");
	a_startup_code: assert property (state_reg inside {MS_STARTUP, MS_ADDR_BAD, MS_CFG_REQ} && !FIELDBUS_UP_I && quiet |=> MODULE_STATE_O == 8'h01)
		else $error("start-up code not reported");
	a_normal_code: assert property (state_reg == MS_NORMAL |-> MODULE_STATE_O == 8'h06)
		else $error("normal state code wrong");
	a_brake_test: assert property (state_reg == MS_NORMAL && brk_sync_reg && ready_state == MS_NORMAL && quiet && !INV_REQ_I |=> MODULE_STATE_O == 8'h07)
		else $error("brake test code not reported");
	a_io_fail_force: assert property (MODULE_STATE_O == 8'h08 |-> TORQUE_OFF_FORCE_O && BRAKE_FORCE_O == 2'b11)
		else $error("fault state without forced outputs");
	a_fatal_latch: assert property (FATAL_I |=> (MODULE_STATE_O == 8'h09 && TORQUE_OFF_FORCE_O)[*8])
		else $error("internal failure not latched");
	a_reset_code: assert property (disable iff (1'b0) RST_I |=> MODULE_STATE_O == 8'h01 && mon_src[0] == 8'h01 && mon_axis[1] == 8'h01)
		else $error("reset values wrong");
endmodule

// ==== rtl/safety_state_pkg.sv ====
// Types shared by the safety state and monitor block.
// Assumes no other package.
package safety_state_pkg;
	typedef enum logic [3:0] {
		MS_STARTUP,
		MS_ADDR_BAD,
		MS_CFG_REQ,
		MS_CFG_BAD,
		MS_PARAM_VAL,
		MS_NORMAL,
		MS_BRAKE_TEST,
		MS_IO_FAIL,
		MS_INT_FAIL
	} mstate_t;
endpackage

// ==== verification/host_model.sv ====
// Host model: issues the parameter invalidation command with parsed arguments.
// Assumes the bench raises go_i for one cycle per command.
`timescale 1ns/1ps
module host_model (
	// Control from the bench
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic [1:0] fault_i,
	// Command to the device
	output logic            req_o = 1'b0,
	output logic [4:0]      name_len_o = 5'h00,
	output logic [4:0]      pass_len_o = 5'h00,
	output logic            time_ok_o = 1'b0
);
	logic long_reg = 1'b0;
	// Arguments sit at range ends; fault_i breaks one on purpose.
	// Outside a command they toggle, so stale values look valid only every other cycle.
	always @(posedge clk_i) begin
		req_o <= go_i;
		if (go_i) begin
			name_len_o <= (fault_i == 2'h1) ? 5'h09 : 5'h08;
			pass_len_o <= (fault_i == 2'h2) ? 5'h07 : (long_reg ? 5'h19 : 5'h08);
			time_ok_o  <= (fault_i != 2'h3);
			long_reg   <= ~long_reg;
		end else begin
			name_len_o <= ~name_len_o;
			pass_len_o <= ~pass_len_o;
			time_ok_o  <= ~time_ok_o;
		end
	end
endmodule

// ==== verification/testbench.sv ====
// Bench for the safety state and monitor block: state walk,
// invalidation, object read and random monitor selections.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
module testbench;
	logic        clk = 1'b0, rst = 1'b1, go = 1'b0, par_req = 1'b0, od_req = 1'b0;
	logic        par_wr = 1'b0, par_ch = 1'b0, fb_up = 1'b0, addr_ok = 1'b0, cfg_load = 1'b0;
	logic        cfg_bad = 1'b0, p_val = 1'b0, io_f = 1'b0, io_ack = 1'b0, fatal = 1'b0;
	logic        brk = 1'b0, c, ok, par_ack, par_err, od_ack, od_err, inv_ack, inv_err;
	logic        pval, to_f, inv_req, tm_ok;
	logic [1:0]  flt = 2'h0, brk_f;
	logic [2:0]  par_sel = 3'h0, s;
	logic [4:0]  nl, pl;
	logic [7:0]  par_wd = 8'h00, od_sub = 8'h00, od_d, mstate, d;
	logic [15:0] od_idx = 16'h0, tos = 16'h0, css = 16'h0, bcs = 16'h0, bs = 16'h0;
	logic [31:0] par_rd, mon1, mon2, rng = 32'h20;
	logic [7:0]  sel_m [2][4];
	int          fail_count = 0, checked = 0;

	always #12.5 clk = ~clk;

	host_model host_model_i (.clk_i(clk), .go_i(go), .fault_i(flt), .req_o(inv_req),
		.name_len_o(nl), .pass_len_o(pl), .time_ok_o(tm_ok));
	safety_state_monitor safety_state_monitor_i (.CLK_SYS_I(clk), .RST_I(rst),
		.PAR_REQ_I(par_req), .PAR_WR_I(par_wr), .PAR_CH_I(par_ch), .PAR_SEL_I(par_sel),
		.PAR_WDATA_I(par_wd), .PAR_ACK_O(par_ack), .PAR_ERR_O(par_err), .PAR_RDATA_O(par_rd),
		.OD_REQ_I(od_req), .OD_INDEX_I(od_idx), .OD_SUB_I(od_sub), .OD_ACK_O(od_ack),
		.OD_ERR_O(od_err), .OD_DATA_O(od_d), .INV_REQ_I(inv_req), .INV_NAME_LEN_I(nl),
		.INV_PASS_LEN_I(pl), .INV_TIME_OK_I(tm_ok), .INV_ACK_O(inv_ack), .INV_ERR_O(inv_err),
		.FIELDBUS_UP_I(fb_up), .ADDR_VALID_I(addr_ok), .CFG_LOAD_I(cfg_load),
		.CFG_BAD_I(cfg_bad), .PARAM_VALIDATE_I(p_val), .IO_FAULT_I(io_f), .IO_ACK_I(io_ack),
		.FATAL_I(fatal), .BRAKE_TEST_I(brk), .TORQUE_OFF_STATE_I(tos),
		.CTL_STOP_STATE_I(css), .BRAKE_CTL_STATE_I(bcs), .BRAKE_STATE_I(bs),
		.MODULE_STATE_O(mstate), .PARAMS_VALID_O(pval), .TORQUE_OFF_FORCE_O(to_f),
		.BRAKE_FORCE_O(brk_f), .MON1_VALUE_O(mon1), .MON2_VALUE_O(mon2));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Sources 1-3 pick a byte by axis, source 4 a brake by instance
	function automatic logic [31:0] ev(input logic ch);
		logic [15:0] w;
		w = (sel_m[ch][1] == 8'h01) ? tos : (sel_m[ch][1] == 8'h02) ? css :
			(sel_m[ch][1] == 8'h03) ? bcs : bs;
		if (sel_m[ch][1] inside {[8'h01:8'h03]})
			return {24'h0, (sel_m[ch][2] == 8'h02) ? w[15:8] : w[7:0]};
		if (sel_m[ch][1] == 8'h04 && sel_m[ch][3] <= 8'h02)
			return {24'h0, (sel_m[ch][3] == 8'h02) ? w[15:8] : w[7:0]};
		return 32'h0;
	endfunction

	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task par(input logic w, input logic ch, input logic [2:0] sl, input logic [7:0] dt);
		@(posedge clk);
		par_req <= 1'b1;
		{par_wr, par_ch, par_sel, par_wd} <= {w, ch, sl, dt};
		@(posedge clk);
		par_req <= 1'b0;
		#1;
		chk("par_ack", par_ack, 32'h1);
	endtask

	task od(input logic [15:0] idx, input logic [7:0] sub, input logic e);
		@(posedge clk);
		od_req <= 1'b1;
		{od_idx, od_sub} <= {idx, sub};
		@(posedge clk);
		od_req <= 1'b0;
		#1;
		chk("od_resp", {od_ack, od_err, od_d}, {1'b1, e, e ? 8'h00 : 8'h06});
	endtask

	task inv(input logic [1:0] f, input logic e);
		@(posedge clk);
		go <= 1'b1;
		flt <= f;
		@(posedge clk);
		go <= 1'b0;
		step(1);
		chk("inv_resp", {inv_ack, inv_err}, {1'b1, e});
	endtask

	// Status bits: up, addr, load, bad, validate, fault, ack, fatal, brake test
	task stat(input logic [8:0] v, input logic [7:0] e);
		@(posedge clk);
		{fb_up, addr_ok, cfg_load, cfg_bad, p_val, io_f, io_ack, fatal, brk} <= v;
		@(posedge clk);
		{cfg_load, p_val, io_ack} <= 3'h0;
		step(4);
		chk("state", mstate, e);
	endtask

	task defaults;
		for (int i = 0; i < 2; i++)
			for (int j = 1; j < 4; j++) begin
				sel_m[i][j] = 8'h01;
				par(1'b0, i[0], 3'(j), 8'h00);
				chk("default", par_rd, 32'h1);
			end
	endtask

	task summarize;
		if (fail_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		step(1);
		chk("reset", {mstate, pval}, {8'h01, 1'b0});
		defaults();
		stat(9'h000, 8'h01);
		stat(9'h100, 8'h02);
		stat(9'h1a0, 8'h04);
		stat(9'h180, 8'h03);
		stat(9'h1c0, 8'h05);
		inv(2'h0, 1'b1);
		chk("state", mstate, 8'h05);
		stat(9'h190, 8'h06);
		for (int f = 1; f < 4; f++)
			inv(2'(f), 1'b1);
		chk("state", mstate, 8'h06);
		inv(2'h0, 1'b0);
		chk("inval", {mstate, pval}, {8'h03, 1'b0});
		stat(9'h1c0, 8'h05);
		stat(9'h190, 8'h06);
		od(16'h37c1, 8'h00, 1'b0);
		od(16'h37c0, 8'h00, 1'b1);
		od(16'h37c1, 8'h01, 1'b1);
		for (int k = 0; k < 80; k++) begin
			rng = xs(rng);
			c = rng[0];
			s = rng[3:1] % 3'h6;
			d = (s == 3'h1) ? 8'(rng[10:8]) % 8'h06 + (rng[11] ? 8'h00 : 8'h11) : 8'(rng[10:8]);
			ok = (s == 3'h1 && d <= 8'h14) || (s == 3'h2 && d inside {[8'h01:8'h02]}) ||
				(s == 3'h3 && d inside {[8'h01:8'h04]});
			@(posedge clk);
			{tos, css, bcs, bs} <= {rng, xs(~rng)};
			par(1'b1, c, s, d);
			chk("wr_err", par_err, 32'(!ok));
			if (ok)
				sel_m[c][s] = d;
			step(2);
			chk("mon1", mon1, ev(1'b0));
			chk("mon2", mon2, ev(1'b1));
			s = (s inside {[3'h1:3'h3]}) ? s : 3'h4;
			par(1'b0, c, s, 8'h00);
			chk("rdata", par_rd, (s == 3'h4) ? ev(c) : {24'h0, sel_m[c][s]});
		end
		stat(9'h181, 8'h07);
		inv(2'h0, 1'b1);
		stat(9'h180, 8'h06);
		stat(9'h188, 8'h08);
		chk("force", {to_f, brk_f}, 32'h7);
		stat(9'h184, 8'h06);
		chk("force", {to_f, brk_f}, 32'h0);
		stat(9'h182, 8'h09);
		stat(9'h180, 8'h09);
		chk("force", {to_f, brk_f}, 32'h7);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		chk("state", mstate, 8'h01);
		step(1);
		chk("state", mstate, 8'h03);
		defaults();
		summarize();
	end

	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		summarize();
	end
endmodule
